/* File: common/fsob_pkg.sv */
// Package for the fan slope and overtemperature boost block.
// Assumes temperatures arrive as unsigned whole degrees, one count per degree.
package fsob_pkg;
	localparam int NCH = 3;
	localparam logic [7:0] OFF_R1_SPAN  = 8'h5f;
	localparam logic [7:0] OFF_LOC_SPAN = 8'h60;
	localparam logic [7:0] OFF_R2_SPAN  = 8'h61;
	localparam logic [7:0] OFF_HYST_A   = 8'h6d;
	localparam logic [7:0] OFF_HYST_B   = 8'h6e;
	localparam int SPAN_MSB = 7;
	localparam int SPAN_LSB = 4;
	localparam logic [7:0] SPAN_CFG_RESET = 8'hc0;
	localparam logic [7:0] HYST_RESET     = 8'h44;
	localparam logic [7:0] DUTY_FULL      = 8'hff;
	localparam int DUTY_SPAN = 170;
	// Span temperatures in hundredths of a degree, codes 0000..1111
	localparam logic [12:0] SPAN_X100 [16] = '{
		13'h00c8, 13'h00fa, 13'h014d, 13'h0190, 13'h01f4, 13'h029b, 13'h0320, 13'h03e8,
		13'h0535, 13'h0640, 13'h07d0, 13'h0a6b, 13'h0c80, 13'h0fa0, 13'h14d5, 13'h1f40};
endpackage : fsob_pkg

/* File: hdl/fsob_ramp.sv */
// Per-channel duty ramp: duty from temperature above the fan-on point.
// Assumes settings are stable and one result per cycle is enough.
`timescale 1ns/100ps
module fsob_ramp (
	input  wire logic [7:0] temp,
	input  wire logic [7:0] fan_on_temperature,
	input  wire logic [3:0] span_code,
	input  wire logic [7:0] min_duty,
	output logic      [7:0] duty,
	output logic            above_on
);
	logic [8:0]  delta;
	logic [29:0] rise;
	logic [29:0] total;
	always_comb begin
		delta    = {1'b0, temp} - {1'b0, fan_on_temperature};
		above_on = temp > fan_on_temperature;
		// Fixed slope: 170 counts per span, independent of min duty
		rise     = 30'(delta) * 30'(fsob_pkg::DUTY_SPAN) * 30'h64
			/ 30'(fsob_pkg::SPAN_X100[span_code]);
		total    = rise + 30'(min_duty);
		if (!above_on)
			duty = 8'h00;
		else if (total > 30'(fsob_pkg::DUTY_FULL))
			duty = fsob_pkg::DUTY_FULL;
		else
			duty = total[7:0];
	end
endmodule : fsob_ramp

/* File: hdl/fsob_top.sv */
// Fan slope and overtemperature boost stage for three temperature channels.
// Assumes temperatures and limits come from logic on ref_clk, not from pins.
`timescale 1ns/100ps
module fsob_top (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic [23:0] temp,
	input  wire logic [23:0] fan_on_temperature,
	input  wire logic [23:0] critical_temp_limit,
	input  wire logic [23:0] min_duty,
	input  wire logic [23:0] max_duty,
	output logic      [23:0] duty,
	output logic             boost_active
);
	logic [7:0] span_cfg_reg [3];
	logic [7:0] hyst_a_reg;
	logic [7:0] hyst_b_reg;
	logic [2:0] crit_reg;
	logic [2:0] crit_next;
	logic [3:0] hyst [3];
	logic [7:0] ramp_duty [3];

	// Registers at their own offsets; index 0 remote1, 1 local, 2 remote2
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++)
				span_cfg_reg[i] <= fsob_pkg::SPAN_CFG_RESET;
			hyst_a_reg <= fsob_pkg::HYST_RESET;
			hyst_b_reg <= fsob_pkg::HYST_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				fsob_pkg::OFF_R1_SPAN:  span_cfg_reg[0] <= reg_wdata;
				fsob_pkg::OFF_LOC_SPAN: span_cfg_reg[1] <= reg_wdata;
				fsob_pkg::OFF_R2_SPAN:  span_cfg_reg[2] <= reg_wdata;
				fsob_pkg::OFF_HYST_A:   hyst_a_reg <= reg_wdata;
				fsob_pkg::OFF_HYST_B:   hyst_b_reg <= {reg_wdata[7:4], 4'h0};
				default: ;
			endcase
		end
	end

	// Reads are registered so the port comes from a flip-flop
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else begin
			unique case (reg_addr)
				fsob_pkg::OFF_R1_SPAN:  reg_rdata <= span_cfg_reg[0];
				fsob_pkg::OFF_LOC_SPAN: reg_rdata <= span_cfg_reg[1];
				fsob_pkg::OFF_R2_SPAN:  reg_rdata <= span_cfg_reg[2];
				fsob_pkg::OFF_HYST_A:   reg_rdata <= hyst_a_reg;
				fsob_pkg::OFF_HYST_B:   reg_rdata <= hyst_b_reg;
				default:                reg_rdata <= {5'h00, crit_reg};
			endcase
		end
	end

	always_comb begin
		hyst[0] = hyst_a_reg[7:4];
		hyst[1] = hyst_a_reg[3:0];
		hyst[2] = hyst_b_reg[7:4];
	end

	for (genvar c = 0; c < 3; c++) begin : g_ch
		fsob_ramp u_ramp (
			.temp               (temp[c*8 +: 8]),
			.fan_on_temperature (fan_on_temperature[c*8 +: 8]),
			.span_code          (span_cfg_reg[c][fsob_pkg::SPAN_MSB:fsob_pkg::SPAN_LSB]),
			.min_duty           (min_duty[c*8 +: 8]),
			.duty               (ramp_duty[c]),
			.above_on           ()
		);
	end

	// Per-channel critical latch with hysteresis release
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			if (temp[c*8 +: 8] > critical_temp_limit[c*8 +: 8])
				crit_next[c] = 1'b1;
			else if ({1'b0, temp[c*8 +: 8]} + {5'h00, hyst[c]} < {1'b0, critical_temp_limit[c*8 +: 8]})
				crit_next[c] = 1'b0;
			else
				crit_next[c] = crit_reg[c];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			crit_reg <= 3'h0;
		else
			crit_reg <= crit_next;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			boost_active <= 1'b0;
		else
			boost_active <= |crit_next;
	end

	// Override is unconditional: no configuration bit reaches it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			duty <= 24'h000000;
		else begin
			for (int c = 0; c < 3; c++) begin
				if (|crit_next)
					duty[c*8 +: 8] <= fsob_pkg::DUTY_FULL;
				else if (ramp_duty[c] > max_duty[c*8 +: 8])
					duty[c*8 +: 8] <= max_duty[c*8 +: 8];
				else
					duty[c*8 +: 8] <= ramp_duty[c];
			end
		end
	end

	property p_boost_full;
		@(posedge ref_clk) disable iff (!rst_n)
		boost_active |-> duty == 24'hffffff;
	endproperty
	a_boost_full: assert property (p_boost_full) else $error("boost without full duty");

	property p_over_limit;
		@(posedge ref_clk) disable iff (!rst_n)
		(temp[7:0] > critical_temp_limit[7:0] || temp[15:8] > critical_temp_limit[15:8]
			|| temp[23:16] > critical_temp_limit[23:16])
		|=> boost_active && duty == 24'hffffff;
	endproperty
	a_over_limit: assert property (p_over_limit) else $error("limit crossing ignored");

	// Latched on remote2 and not yet below its limit minus hysteresis
	sequence s_r2_latched;
		crit_reg[2]
		&& ({1'b0, temp[23:16]} + {5'h00, hyst_b_reg[7:4]} >= {1'b0, critical_temp_limit[23:16]});
	endsequence

	property p_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		s_r2_latched |=> boost_active && duty == 24'hffffff;
	endproperty
	a_hold: assert property (p_hold) else $error("boost released early");

	// Widened by one bit so temperature plus hysteresis cannot wrap
	sequence s_all_clear;
		({1'b0, temp[7:0]} + {5'h00, hyst_a_reg[7:4]} < {1'b0, critical_temp_limit[7:0]})
		&& ({1'b0, temp[15:8]} + {5'h00, hyst_a_reg[3:0]} < {1'b0, critical_temp_limit[15:8]})
		&& ({1'b0, temp[23:16]} + {5'h00, hyst_b_reg[7:4]} < {1'b0, critical_temp_limit[23:16]});
	endsequence

	property p_release;
		@(posedge ref_clk) disable iff (!rst_n)
		s_all_clear |=> !boost_active;
	endproperty
	a_release: assert property (p_release) else $error("boost held past release point");

	property p_cap;
		@(posedge ref_clk) disable iff (!rst_n)
		!boost_active |-> duty[15:8] <= $past(max_duty[15:8]);
	endproperty
	a_cap: assert property (p_cap) else $error("duty above maximum");

	property p_off;
		@(posedge ref_clk) disable iff (!rst_n)
		(temp[23:16] <= fan_on_temperature[23:16] && !(|crit_next)) |=> duty[23:16] == 8'h00;
	endproperty
	a_off: assert property (p_off) else $error("fan on below fan-on point");

	property p_start_min;
		@(posedge ref_clk) disable iff (!rst_n)
		(temp[7:0] > fan_on_temperature[7:0] && !(|crit_next) && max_duty[7:0] == 8'hff)
		|=> duty[7:0] >= $past(min_duty[7:0]);
	endproperty
	a_start_min: assert property (p_start_min) else $error("duty below minimum");

	property p_slope;
		@(posedge ref_clk) disable iff (!rst_n)
		({1'b0, temp[7:0]} == {1'b0, fan_on_temperature[7:0]} + 9'h001
			&& span_cfg_reg[0][fsob_pkg::SPAN_MSB:fsob_pkg::SPAN_LSB] == 4'h0
			&& min_duty[7:0] == 8'h00 && max_duty[7:0] == 8'hff && !(|crit_next))
		|=> duty[7:0] == 8'h55;
	endproperty
	a_slope: assert property (p_slope) else $error("slope wrong");

	property p_sat;
		@(posedge ref_clk) disable iff (!rst_n)
		// Three degrees on the steepest span already reach full scale
		({1'b0, temp[7:0]} >= {1'b0, fan_on_temperature[7:0]} + 9'h003
			&& span_cfg_reg[0][fsob_pkg::SPAN_MSB:fsob_pkg::SPAN_LSB] == 4'h0
			&& max_duty[7:0] == 8'hff)
		|=> duty[7:0] == 8'hff;
	endproperty
	a_sat: assert property (p_sat) else $error("no saturation");

	property p_span_write;
		@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == fsob_pkg::OFF_R1_SPAN) |=> span_cfg_reg[0] == $past(reg_wdata);
	endproperty
	a_span_write: assert property (p_span_write) else $error("remote1 span write lost");

	property p_hyst_b_write;
		@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == fsob_pkg::OFF_HYST_B)
		|=> hyst_b_reg == {$past(reg_wdata[7:4]), 4'h0};
	endproperty
	a_hyst_b_write: assert property (p_hyst_b_write) else $error("remote2 hysteresis write wrong");

	property p_rd_local;
		@(posedge ref_clk) disable iff (!rst_n)
		reg_addr == fsob_pkg::OFF_LOC_SPAN |=> reg_rdata == $past(span_cfg_reg[1]);
	endproperty
	a_rd_local: assert property (p_rd_local) else $error("local span read wrong");
endmodule : fsob_top

/* File: verif/fsob_fan_model.sv */
// Fan model standing on one duty output.
// Assumes the duty word is settled at each rising edge of ref_clk.
`timescale 1ns/100ps
module fsob_fan_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] duty,
	output logic            full_speed
);
	// Only full drive is visible here; partial speed would need a tach model
	always_ff @(posedge ref_clk) begin
		full_speed <= (duty == fsob_pkg::DUTY_FULL);
	end
endmodule : fsob_fan_model

/* File: verif/test_fan_slope_and_overtemp_boost.sv */
// Bench for the fan slope and overtemperature boost stage.
// Assumes one write per falling edge and results settled two edges later.
`timescale 1ns/100ps
module test_fan_slope_and_overtemp_boost;
	logic        ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [23:0] temp = 24'h0, fan_on_temperature = 24'h1e1e1e;
	logic [23:0] critical_temp_limit = 24'hc8c8c8, min_duty = 24'h0;
	logic [23:0] max_duty = 24'hffffff, duty;
	logic        boost_active, full_speed;
	int          fail_count = 0, compares = 0;
	// Span code, min duty, max duty, temperature, expected duty
	logic [7:0]  rows [9][5] = '{
		'{8'h0d, 8'h55, 8'hff, 8'h46, 8'hff}, '{8'h0d, 8'h1a, 8'hff, 8'h1e, 8'h00},
		'{8'h0d, 8'h1a, 8'hff, 8'h1f, 8'h1e}, '{8'h0d, 8'h80, 8'hff, 8'h3c, 8'hff},
		'{8'h00, 8'h00, 8'hff, 8'h1f, 8'h55}, '{8'h0f, 8'h00, 8'hff, 8'h6e, 8'haa},
		'{8'h00, 8'h64, 8'hff, 8'h64, 8'hff}, '{8'h0d, 8'h1a, 8'h80, 8'h54, 8'h80},
		'{8'h0c, 8'h00, 8'hff, 8'h3e, 8'haa}};

	fsob_top u_fsob_top (.ref_clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
		.temp, .fan_on_temperature, .critical_temp_limit, .min_duty, .max_duty,
		.duty, .boost_active);
	fsob_fan_model u_fsob_fan_model (.ref_clk, .duty(duty[7:0]), .full_speed);

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic settle;
		repeat (2) @(negedge ref_clk);
	endtask : settle

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	// Whole run needs under 100 cycles; allow about five times that
	initial begin
		#20000;
		fail_count++;
		give_verdict();
	end

	initial begin
		repeat (12) @(negedge ref_clk);
		chk({duty, boost_active}, 25'h0);
		rst_n = 1'b1;
		reg_addr = 8'h60;
		settle();
		chk(reg_rdata, 8'hc0);
		reg_addr = 8'h6d;
		settle();
		chk(reg_rdata, 8'h44);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(8'h5f, {rows[i][0][3:0], 4'h0});
			min_duty[7:0] = rows[i][1];
			max_duty[7:0] = rows[i][2];
			temp[7:0] = rows[i][3];
			settle();
			chk(duty[7:0], rows[i][4]);
			chk(reg_rdata, {rows[i][0][3:0], 4'h0});
		end
		$display("ramp rows done");
		wr(8'h60, 8'h00);
		wr(8'h61, 8'hf0);
		temp = 24'h1f1f1f;
		min_duty = 24'h0;
		settle();
		chk(duty, 24'h025505);
		$display("channel map test done");
		critical_temp_limit[23:16] = 8'h64;
		max_duty = 24'h101010;
		temp[23:16] = 8'h65;
		reg_addr = 8'h70;
		settle();
		chk(duty, 24'hffffff);
		chk({boost_active, full_speed}, 2'b11);
		chk(reg_rdata, 8'h04);
		temp[23:16] = 8'h61;
		settle();
		chk(duty, 24'hffffff);
		temp[23:16] = 8'h5f;
		settle();
		chk({duty, boost_active}, {24'h101005, 1'b0});
		$display("boost test done");
		wr(8'h6d, 8'h21);
		settle();
		chk(reg_rdata, 8'h21);
		wr(8'h6e, 8'h2f);
		temp[23:16] = 8'h65;
		settle();
		chk({reg_rdata, duty}, {8'h20, 24'hffffff});
		temp[23:16] = 8'h62;
		settle();
		chk(boost_active, 1'b1);
		temp[23:16] = 8'h61;
		settle();
		chk({boost_active, duty}, {1'b0, 24'h101005});
		$display("hysteresis test done");
		reg_addr = 8'h61;
		rst_n = 1'b0;
		@(negedge ref_clk);
		rst_n = 1'b1;
		settle();
		chk(reg_rdata, 8'hc0);
		$display("mid-run reset test done");
		give_verdict();
	end
endmodule : test_fan_slope_and_overtemp_boost
